// ==== hdl/mcpwm_params.svh ====
// Constants for the multi-channel pulse-width-modulation bank
`ifndef MCPWM_PARAMS_SVH
`define MCPWM_PARAMS_SVH

// Channel count and divider width
`define MCPWM_NUM_CH    6
`define MCPWM_MAX_CH    6
`define MCPWM_DIV_W     16
`define MCPWM_MIN_DIV_W 2

// Divider reset value and the least phase length in input clock ticks
`define MCPWM_DIV_RST   16'h0001
`define MCPWM_DIV_ZERO  16'h0000

// Input clock source selection
`define MCPWM_SRC_PLL   1'b0
`define MCPWM_SRC_XTAL  1'b1

`endif

// ==== hdl/mcpwm_pkg.sv ====
// Types shared by the pulse-width-modulation bank
package mcpwm_pkg;

	// Channel sequencer, Gray coded along idle, high, low, done
	typedef enum logic [1:0]
	{
		MCPWM_IDLE = 2'h0,
		MCPWM_HIGH = 2'h1,
		MCPWM_LOW  = 2'h3,
		MCPWM_DONE = 2'h2
	} mcpwm_state_t;

endpackage

// ==== hdl/mcpwm_channel.sv ====
// One pulse-width-modulation channel: a single counter times both the high and the low phase
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_params.svh"

module mcpwm_channel
	import mcpwm_pkg::*;
#(
	parameter int DIV_W = `MCPWM_DIV_W
)
(
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_resetn,
	// Selected input clock tick and control
	input  wire logic             i_tick,
	input  wire logic             i_enable,
	input  wire logic             i_one_shot,
	// Divider values in force for the next phase
	input  wire logic [DIV_W-1:0] i_high_load,
	input  wire logic [DIV_W-1:0] i_low_load,
	// State towards the bank
	output logic                  o_level,
	output logic                  o_idle,
	output logic                  o_boundary
);

	localparam logic [DIV_W-1:0] ONE  = DIV_W'(`MCPWM_DIV_RST);
	localparam logic [DIV_W-1:0] ZERO = DIV_W'(`MCPWM_DIV_ZERO);

	mcpwm_state_t     state;
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] high_eff;
	logic [DIV_W-1:0] low_eff;

	// A zero divider would wrap the counter into the longest phase, so it counts as one tick
	always_comb
	begin
		high_eff   = (i_high_load == ZERO) ? ONE : i_high_load;
		low_eff    = (i_low_load == ZERO) ? ONE : i_low_load;
		o_level    = (state == MCPWM_HIGH);
		o_idle     = (state == MCPWM_IDLE) || (state == MCPWM_DONE);
		o_boundary = i_tick && (state == MCPWM_LOW) && (cnt == ONE);
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state <= MCPWM_IDLE;
			cnt   <= ONE;
		end
		else if (!i_enable)
		begin
			state <= MCPWM_IDLE;
			cnt   <= ONE;
		end
		else
		begin
			case (state)
				MCPWM_IDLE:
				begin
					state <= MCPWM_HIGH;
					cnt   <= high_eff;
				end
				MCPWM_HIGH:
				begin
					if (i_tick)
					begin
						if (cnt == ONE)
						begin
							state <= MCPWM_LOW;
							cnt   <= low_eff;
						end
						else
							cnt <= cnt - ONE;
					end
				end
				MCPWM_LOW:
				begin
					if (i_tick)
					begin
						if (cnt == ONE)
						begin
							if (i_one_shot)
								state <= MCPWM_DONE;
							else
							begin
								state <= MCPWM_HIGH;
								cnt   <= high_eff;
							end
						end
						else
							cnt <= cnt - ONE;
					end
				end
				MCPWM_DONE:
					state <= MCPWM_DONE;
				default:
					state <= MCPWM_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	a_count_holds: assert property (i_enable && !i_tick && state != MCPWM_IDLE ##1 i_enable |-> $stable(cnt))
		else $error("phase counter moved without an input clock tick");
	a_high_to_low: assert property (i_enable && state == MCPWM_HIGH && i_tick && cnt == ONE ##1 i_enable
		|-> state == MCPWM_LOW && cnt == $past(low_eff))
		else $error("high phase did not hand over to low phase");
	a_single_stop: assert property (o_boundary && i_enable && i_one_shot ##1 i_enable
		|-> state == MCPWM_DONE ##1 (!i_enable || !o_level))
		else $error("single pulse did not stop");

endmodule
`default_nettype wire

// ==== hdl/mcpwm_bank.sv ====
// Bank of independent pulse-width-modulation channels with staged updates
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_params.svh"

// How it works
// - Up to six channels run independently, each with its own controls.
// - Each channel outputs a square wave with programmable duty cycle.
// - Phase timing comes from counting ticks of the selected input clock.
// - Separate 16-bit high and low dividers, each set independently.
// - New settings apply per channel or together on one group commit.
// - A channel pair may invert its odd output for differential drive.
// - Each channel runs continuously or emits one pulse and stops.
// - Input clock per channel is the PLL clock or the crystal clock.

module mcpwm_bank
	import mcpwm_pkg::*;
#(
	parameter int NUM_CH = `MCPWM_NUM_CH,
	parameter int DIV_W  = `MCPWM_DIV_W
)
(
	// Clock and reset
	input  wire logic                    i_clock,
	input  wire logic                    i_resetn,
	// Candidate input clocks, asynchronous to i_clock
	input  wire logic                    i_pll_clk,
	input  wire logic                    i_xtal_clk,
	// Per channel controls
	input  wire logic [NUM_CH-1:0]       i_enable,
	input  wire logic [NUM_CH-1:0]       i_clk_sel,
	input  wire logic [NUM_CH-1:0]       i_one_shot,
	input  wire logic [NUM_CH-1:0]       i_sync_group,
	// Divider writes
	input  wire logic [NUM_CH-1:0]       i_write,
	input  wire logic [NUM_CH*DIV_W-1:0] i_high_div,
	input  wire logic [NUM_CH*DIV_W-1:0] i_low_div,
	input  wire logic                    i_sync_commit,
	// Pair inversion, one bit per channel pair
	input  wire logic [NUM_CH/2-1:0]     i_pair_invert,
	// Outputs and status
	output logic      [NUM_CH-1:0]       o_pwm,
	output logic      [NUM_CH-1:0]       o_busy,
	output logic      [NUM_CH-1:0]       o_pending,
	output logic      [NUM_CH-1:0]       o_staged
);

	localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(`MCPWM_DIV_RST);

	generate
		if (NUM_CH < 1 || NUM_CH > `MCPWM_MAX_CH)
			$error("channel count out of range");
		if (DIV_W < `MCPWM_MIN_DIV_W)
			$error("divider width too small");
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Input clock sampling
	// Each source must run below half of i_clock, since its edges are found
	// by sampling; the two-stage synchroniser adds two cycles of latency.

	logic [2:0]        pll_sync;
	logic [2:0]        xtal_sync;
	logic              pll_tick;
	logic              xtal_tick;
	logic [NUM_CH-1:0] tick;

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pll_sync  <= 3'h0;
			xtal_sync <= 3'h0;
		end
		else
		begin
			pll_sync  <= {pll_sync[1:0], i_pll_clk};
			xtal_sync <= {xtal_sync[1:0], i_xtal_clk};
		end
	end

	always_comb
	begin
		pll_tick  = pll_sync[1] && !pll_sync[2];
		xtal_tick = xtal_sync[1] && !xtal_sync[2];
		for (int c = 0; c < NUM_CH; c++)
			tick[c] = (i_clk_sel[c] == `MCPWM_SRC_XTAL) ? xtal_tick : pll_tick;
	end

	////////////////////////////////////////////////////////////////////////////
	// Shadow, pending and active divider values

	logic [NUM_CH-1:0][DIV_W-1:0] shadow_high;
	logic [NUM_CH-1:0][DIV_W-1:0] shadow_low;
	logic [NUM_CH-1:0][DIV_W-1:0] active_high;
	logic [NUM_CH-1:0][DIV_W-1:0] active_low;
	logic [NUM_CH-1:0][DIV_W-1:0] next_active_high;
	logic [NUM_CH-1:0][DIV_W-1:0] next_active_low;
	logic [NUM_CH-1:0]            pending;
	logic [NUM_CH-1:0]            staged;
	logic [NUM_CH-1:0]            arm;
	logic [NUM_CH-1:0]            apply;
	logic [NUM_CH-1:0]            level;
	logic [NUM_CH-1:0]            idle;
	logic [NUM_CH-1:0]            boundary;

	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			// Ungrouped channels arm on their own write, grouped ones on commit
			arm[c]   = (i_write[c] && !i_sync_group[c])
				|| (i_sync_commit && i_sync_group[c] && staged[c]);
			apply[c] = pending[c] && (boundary[c] || idle[c]);
			next_active_high[c] = apply[c] ? shadow_high[c] : active_high[c];
			next_active_low[c]  = apply[c] ? shadow_low[c] : active_low[c];
		end
	end

	// A write replaces the shadow at once; the running period keeps old values
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			shadow_high <= {NUM_CH{DIV_RST}};
			shadow_low  <= {NUM_CH{DIV_RST}};
		end
		else
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				if (i_write[c])
				begin
					shadow_high[c] <= i_high_div[c*DIV_W +: DIV_W];
					shadow_low[c]  <= i_low_div[c*DIV_W +: DIV_W];
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			active_high <= {NUM_CH{DIV_RST}};
			active_low  <= {NUM_CH{DIV_RST}};
		end
		else
		begin
			active_high <= next_active_high;
			active_low  <= next_active_low;
		end
	end

	// Set wins over clear, so an arm in the apply cycle is never lost
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pending <= '0;
			staged  <= '0;
		end
		else
		begin
			pending <= (pending & ~apply) | arm;
			staged  <= (staged & ~(i_sync_group & {NUM_CH{i_sync_commit}}))
				| (i_write & i_sync_group);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channels

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			mcpwm_channel #(
				.DIV_W (DIV_W)
			) u_ch (
				.i_clock     (i_clock),
				.i_resetn    (i_resetn),
				.i_tick      (tick[g]),
				.i_enable    (i_enable[g]),
				.i_one_shot  (i_one_shot[g]),
				.i_high_load (next_active_high[g]),
				.i_low_load  (next_active_low[g]),
				.o_level     (level[g]),
				.o_idle      (idle[g]),
				.o_boundary  (boundary[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	// The odd channel of an inverted pair follows its even partner, so both
	// edges of the differential pair leave from the same flip-flop update.

	logic [NUM_CH-1:0] next_pwm;

	always_comb
	begin
		next_pwm = level;
		for (int p = 0; p < NUM_CH / 2; p++)
		begin
			if (i_pair_invert[p])
				next_pwm[2*p+1] = !level[2*p];
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_pwm     <= '0;
			o_busy    <= '0;
			o_pending <= '0;
			o_staged  <= '0;
		end
		else
		begin
			o_pwm     <= next_pwm;
			o_busy    <= ~idle;
			o_pending <= pending;
			o_staged  <= staged;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	sequence s_commit(int c);
		i_sync_commit && i_sync_group[c] && staged[c];
	endsequence

	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_chk
			a_own_write_arms: assert property (i_write[g] && !i_sync_group[g] |=> pending[g])
				else $error("ungrouped write did not arm its channel");
			a_group_commit: assert property (s_commit(g) |=> pending[g])
				else $error("group commit did not arm a staged channel");
			a_group_waits: assert property (i_write[g] && i_sync_group[g] && !i_sync_commit
				##1 !i_sync_commit [*2] |-> !$rose(pending[g]))
				else $error("grouped write applied without a commit");
			// Tied to the channel's own state, not to the apply term it should produce
			a_active_boundary: assert property (!(boundary[g] || idle[g])
				|=> $stable(active_high[g]) && $stable(active_low[g]))
				else $error("divider changed away from a period boundary");
			a_apply_value: assert property (i_write[g] && !i_sync_group[g] ##1 apply[g]
				|=> active_high[g] == $past(i_high_div[g*DIV_W +: DIV_W], 2)
				&& active_low[g] == $past(i_low_div[g*DIV_W +: DIV_W], 2))
				else $error("applied divider differs from the written value");
			a_clock_select: assert property (tick[g] == (i_clk_sel[g] ? xtal_tick : pll_tick))
				else $error("channel counts ticks of the wrong input clock");
		end
		for (g = 0; g < NUM_CH / 2; g++)
		begin : g_pair
			a_pair_invert: assert property (i_pair_invert[g] |=> o_pwm[2*g+1] == !$past(level[2*g]))
				else $error("inverted pair output is not the complement");
		end
	endgenerate

	a_output_level: assert property (##1 o_pwm[0] == $past(level[0]))
		else $error("even output does not follow its channel");

endmodule
`default_nettype wire

// ==== test/mcpwm_load.sv ====
// Load model: times every high and low stretch on the outputs it receives
`timescale 1ns/1ps
`default_nettype none

module mcpwm_load
#(
	parameter int NUM_CH = 6
)
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	// Driven waveforms
	input  wire logic [NUM_CH-1:0] i_pwm,
	// Measured lengths in clock cycles, and rising edge counts
	output int                     o_high [NUM_CH],
	output int                     o_low [NUM_CH],
	output int                     o_rises [NUM_CH]
);
	int          run [NUM_CH];
	logic [NUM_CH-1:0] last;

	// A purely passive load; it only watches, so nothing here can upset the bank
	always @(posedge i_clock or negedge i_resetn)
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (!i_resetn)
			begin
				run[c] <= 0;
				o_high[c] <= 0;
				o_low[c] <= 0;
				o_rises[c] <= 0;
			end
			else if (i_pwm[c] !== last[c])
			begin
				if (last[c])
					o_high[c] <= run[c];
				else
					o_low[c] <= run[c];
				if (i_pwm[c])
					o_rises[c] <= o_rises[c] + 1;
				run[c] <= 1;
			end
			else
				run[c] <= run[c] + 1;
		end
		last <= i_resetn ? i_pwm : '0;
	end
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the pulse-width-modulation bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int NC = 6;
	logic              i_clock, i_resetn, pll, xtal, i_sync_commit;
	logic [NC-1:0]     i_enable, i_clk_sel, i_one_shot, i_sync_group, i_write;
	logic [NC-1:0]     o_pwm, o_busy, o_pending, o_staged;
	logic [NC*16-1:0]  i_high_div, i_low_div;
	logic [NC/2-1:0]   i_pair_invert;
	logic [15:0]       hd [NC], ld [NC], oh, ol;
	int                hi [NC], lo [NC], rises [NC];
	int                n_fail, samples_checked, cycles, r0, bad;

	mcpwm_bank mcpwm_bank_inst (.i_clock, .i_resetn, .i_pll_clk(pll), .i_xtal_clk(xtal), .i_enable, .i_clk_sel,
		.i_one_shot, .i_sync_group, .i_write, .i_high_div, .i_low_div, .i_sync_commit, .i_pair_invert,
		.o_pwm, .o_busy, .o_pending, .o_staged);
	mcpwm_load #(.NUM_CH(NC)) mcpwm_load_inst (.i_clock, .i_resetn, .i_pwm(o_pwm), .o_high(hi), .o_low(lo),
		.o_rises(rises));

	// Source clocks run free and out of phase with the system clock
	initial
	begin
		i_clock = 0;
		forever #2.5 i_clock = ~i_clock;
	end
	initial
	begin
		pll = 0;
		#3;
		forever #20 pll = ~pll;
	end
	initial
	begin
		xtal = 0;
		#7;
		forever #35 xtal = ~xtal;
	end

	////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Tick edges are resynchronised, so each stretch may move by a cycle at either end
	task automatic near(string what, int exp, int got);
		samples_checked++;
		if (got < exp - 2 || got > exp + 2)
		begin
			n_fail++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	function automatic int cyc(logic [15:0] d, logic s);
		return ((d == 16'h0000) ? 1 : int'(d)) * (s ? 14 : 8);
	endfunction

	task automatic chk_ch(int c);
		near("high length", cyc(hd[c], i_clk_sel[c]), hi[c]);
		near("low length", cyc(ld[c], i_clk_sel[c]), lo[c]);
	endtask

	task automatic load(logic [NC-1:0] m);
		for (int c = 0; c < NC; c++)
		begin
			i_high_div[c*16+:16] <= hd[c];
			i_low_div[c*16+:16] <= ld[c];
		end
		i_write <= m;
		@(posedge i_clock);
		i_write <= '0;
	endtask

	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			n_fail++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		{n_fail, samples_checked, cycles, bad} = '0;
		{i_resetn, i_sync_commit, i_enable, i_clk_sel, i_one_shot, i_sync_group, i_write} = '0;
		{i_high_div, i_low_div, i_pair_invert} = '0;
		r0 = $urandom(85205);
		repeat (4) @(posedge i_clock);
		chk("idle pwm", {2'h0, o_pwm}, 8'h00);
		chk("idle busy", {2'h0, o_busy}, 8'h00);
		i_resetn <= 1'b1;
		i_clk_sel <= 6'h15;
		for (int c = 0; c < NC; c++)
		begin
			hd[c] = 16'($urandom_range(5, 1));
			ld[c] = 16'($urandom_range(5, 1));
		end
		hd[5] = 16'h0000;
		ld[4] = 16'h0000;
		@(posedge i_clock);
		load('1);
		i_enable <= '1;
		repeat (500) @(posedge i_clock);
		@(negedge i_clock);
		for (int c = 0; c < NC; c++)
			chk_ch(c);
		chk("busy", {2'h0, o_busy}, 8'h3F);
		@(posedge i_clock);
		// Rewrite one running channel; its neighbours must not notice
		hd[0] = 16'($urandom_range(8, 6));
		ld[0] = 16'($urandom_range(8, 6));
		load(6'h01);
		@(posedge i_clock);
		@(negedge i_clock);
		chk("pending", {7'h00, o_pending[0]}, 8'h01);
		repeat (500) @(posedge i_clock);
		for (int c = 0; c < NC; c++)
			chk_ch(c);
		i_sync_group <= 6'h04;
		oh = hd[2];
		ol = ld[2];
		hd[2] = 16'($urandom_range(8, 6));
		ld[2] = 16'($urandom_range(8, 6));
		@(posedge i_clock);
		load(6'h04);
		@(posedge i_clock);
		@(negedge i_clock);
		chk("staged", {6'h00, o_staged[2], o_pending[2]}, 8'h02);
		repeat (400) @(posedge i_clock);
		near("held high", cyc(oh, i_clk_sel[2]), hi[2]);
		near("held low", cyc(ol, i_clk_sel[2]), lo[2]);
		i_sync_commit <= 1'b1;
		@(posedge i_clock);
		i_sync_commit <= 1'b0;
		@(posedge i_clock);
		@(negedge i_clock);
		chk("committed", {6'h00, o_staged[2], o_pending[2]}, 8'h01);
		repeat (500) @(posedge i_clock);
		chk_ch(2);
		i_pair_invert <= 3'h1;
		repeat (5) @(posedge i_clock);
		repeat (300)
		begin
			@(negedge i_clock);
			bad += int'(o_pwm[1] === o_pwm[0]);
		end
		chk("pair mirror", 8'(bad), 8'h00);
		@(posedge i_clock);
		i_pair_invert <= '0;
		i_enable <= '0;
		i_one_shot <= 6'h08;
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
		chk("stopped", {o_pwm, o_busy[1:0]}, 8'h00);
		r0 = rises[3];
		@(posedge i_clock);
		i_enable <= 6'h08;
		repeat (500) @(posedge i_clock);
		@(negedge i_clock);
		chk("single pulse", 8'(rises[3] - r0), 8'h01);
		chk("shot done", {6'h00, o_busy[3], o_pwm[3]}, 8'h00);
		end_sim();
	end
endmodule

`default_nettype wire
